// >>> hw/rcq_top.sv
// Ring cadence qualifier: register slave, cadence checks and ring state
//
// The placing of the registers and register access over Wishbone were decided locally.
`default_nettype none
module rcq_top
  import rcq_pkg::*;
#(
  parameter int TICK_PERIOD = TICK_CYCLES
)
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  input  wire logic        tip_ring_event_in,
  output logic             ring_detect_out,
  output logic             ring_active_out,
  output logic             irq_out
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [7:0]       ctrl;
  logic [CAD_W-1:0] ras;
  logic [7:0]       tmox;
  logic [ST_W-1:0]  status;
  logic [ST_W-1:0]  mask;
  logic [ST_W-1:0]  ev_vec;
  logic [ST_W-1:0]  w1c;
  logic [31:0]      rd_word;
  logic [CAD_W-1:0] cad_cnt;
  logic [CAD_W-1:0] max_cnt;
  logic [TMR_W-1:0] phase_limit;
  logic [PRE_W:0]   tick_since;
  rcq_state_t       state;
  rcq_state_t       next_state;
  logic             bus_req;
  logic             bus_wr;
  logic             enable;
  logic             ev_take;
  logic             checking;
  logic             too_slow;
  logic             too_fast;
  logic             invalid;
  logic             tick;
  logic             pre_clear;
  logic             phase_clear;
  logic             phase_done;
  logic             end_clear;
  logic             end_done;
  logic             ring_over;
  logic             ev_indicate;

  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  // Answer one cycle after the request; the ack gap keeps a held request
  // from being taken twice.
  assign bus_req = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign bus_wr  = bus_req && wb_we_in && wb_sel_in[0];

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      wb_ack_out <= 1'b0;
    else
      wb_ack_out <= bus_req;
  end

  always_comb
  begin
    rd_word = '0;
    case (wb_adr_in)
      OFS_CTRL:
        rd_word[7:0] = {ctrl[7:1], 1'b0};
      OFS_MINF:
        rd_word[CAD_W-1:0] = ras;
      OFS_TMOX:
        rd_word[7:0] = tmox;
      OFS_STAT:
        rd_word[ST_W-1:0] = status;
      OFS_MASK:
        rd_word[ST_W-1:0] = mask;
      OFS_STATE:
      begin
        rd_word[CAD_W-1:0] = cad_cnt;
        rd_word[SR_DET_BIT] = ring_detect_out;
        rd_word[SR_ACT_BIT] = ring_active_out;
      end
      default:
        rd_word = '0;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      wb_dat_out <= '0;
    else if (bus_req && !wb_we_in)
      wb_dat_out <= rd_word;
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  // Bit 0 of the validation control must stay zero, so writes never set it
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      ctrl <= CTRL_RST;
    else if (bus_wr && wb_adr_in == OFS_CTRL)
      ctrl <= {wb_dat_in[7:1], 1'b0};
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      ras <= MINF_RST;
    else if (bus_wr && wb_adr_in == OFS_MINF)
      ras <= wb_dat_in[CAD_W-1:0];
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      tmox <= TMOX_RST;
    else if (bus_wr && wb_adr_in == OFS_TMOX)
      tmox <= wb_dat_in[7:0];
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      mask <= '0;
    else if (bus_wr && wb_adr_in == OFS_MASK)
      mask <= wb_dat_in[ST_W-1:0];
  end

  // ----------------------------------------
  // Interrupt status
  // ----------------------------------------
  assign ev_vec[ST_IND] = ev_indicate;
  assign ev_vec[ST_INV] = invalid;
  assign ev_vec[ST_END] = ring_over;
  assign w1c = (bus_wr && wb_adr_in == OFS_STAT) ? wb_dat_in[ST_W-1:0] : '0;

  // An event in the clearing cycle wins, so none is lost
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      status <= '0;
    else
      status <= (status & ~w1c) | ev_vec;
  end

  assign irq_out = |(status & mask);

  // ----------------------------------------
  // Step tick and cadence checks
  // ----------------------------------------
  assign enable    = ctrl[CTRL_EN_BIT];
  assign ev_take   = enable && tip_ring_event_in;
  assign pre_clear = ev_take || !enable;

  rcq_tick_gen #(
    .CYCLES   (TICK_PERIOD)
  ) u_tick (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .clear_in (pre_clear),
    .tick_out (tick)
  );

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      cad_cnt <= '0;
    else if (!enable)
      cad_cnt <= '0;
    else if (ev_take)
      cad_cnt <= ras;
    else if (tick && cad_cnt != '0)
      cad_cnt <= cad_cnt - 1'b1;
  end

  // Only events after the first one of a qualification are judged
  assign max_cnt  = CAD_W'(tmox[TMOX_RMX_LSB +: 4]);
  assign checking = (state == RCQ_QUAL) || (state == RCQ_DELAY);
  assign too_slow = ev_take && checking && (cad_cnt == '0);
  assign too_fast = ev_take && checking && (cad_cnt > max_cnt);
  assign invalid  = too_slow || too_fast;

  // ----------------------------------------
  // Confirmation, delay and end timers
  // ----------------------------------------
  // One timer serves both phases; it restarts when the phase changes
  assign phase_limit = (state == RCQ_QUAL) ?
                       confirm_ticks(ctrl[CTRL_CC_LSB +: 3]) :
                       delay_ticks(ctrl[CTRL_DLY_LSB +: 3]);
  assign phase_clear = (state == RCQ_IDLE) || invalid ||
                       (state == RCQ_QUAL && next_state == RCQ_DELAY);

  rcq_tick_timer u_phase (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .clear_in (phase_clear),
    .tick_in  (tick),
    .limit_in (phase_limit),
    .done_out (phase_done)
  );

  assign end_clear = ev_take || (state == RCQ_IDLE);

  rcq_tick_timer u_end (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .clear_in (end_clear),
    .tick_in  (tick),
    .limit_in (rto_ticks(tmox[TMOX_RTO_LSB +: 4])),
    .done_out (end_done)
  );

  assign ring_over = enable && (state != RCQ_IDLE) && end_done && !ev_take;

  // ----------------------------------------
  // Ring state
  // ----------------------------------------
  // A rejected event starts a fresh qualification with itself as first
  always_comb
  begin
    next_state = state;
    unique case (state)
      RCQ_IDLE:
        if (ev_take)
          next_state = RCQ_QUAL;
      RCQ_QUAL:
        if (ring_over)
          next_state = RCQ_IDLE;
        else if (phase_done && !invalid)
          next_state = RCQ_DELAY;
      RCQ_DELAY:
        if (ring_over)
          next_state = RCQ_IDLE;
        else if (invalid)
          next_state = RCQ_QUAL;
        else if (phase_done)
          next_state = RCQ_RING;
      RCQ_RING:
        if (ring_over)
          next_state = RCQ_IDLE;
    endcase
    if (!enable)
      next_state = RCQ_IDLE;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      state <= RCQ_IDLE;
    else
      state <= next_state;
  end

  assign ev_indicate = (state != RCQ_RING) && (next_state == RCQ_RING);

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ring_detect_out <= 1'b0;
      ring_active_out <= 1'b0;
    end
    else
    begin
      ring_detect_out <= (next_state == RCQ_RING);
      ring_active_out <= (next_state != RCQ_IDLE);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      tick_since <= '0;
    else if (pre_clear)
      tick_since <= '0;
    else if (tick)
      tick_since <= (PRE_W+1)'(1);
    else
      tick_since <= tick_since + 1'b1;
  end

  default clocking a_clk @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  a_ras_read_zero: assert property (
    wb_ack_out && !wb_we_in && wb_adr_in == OFS_MINF |->
      wb_dat_out[31:CAD_W] == '0 && wb_dat_out[CAD_W-1:0] == ras)
    else $error("assertion field read back wrong");

  a_event_reload: assert property (
    ev_take |=> cad_cnt == $past(ras))
    else $error("cadence counter not reloaded on event");

  a_step_down: assert property (
    tick && !ev_take && enable && cad_cnt != '0 |=>
      cad_cnt == CAD_W'($past(cad_cnt) - 1'b1))
    else $error("cadence counter did not step down on tick");

  a_slow_reject: assert property (
    ev_take && checking && cad_cnt == '0 |=>
      state == RCQ_QUAL && status[ST_INV] && !ring_detect_out)
    else $error("slow ring not rejected");

  a_fast_reject: assert property (
    ev_take && checking && cad_cnt > max_cnt |=>
      state == RCQ_QUAL && status[ST_INV] && cad_cnt == $past(ras))
    else $error("fast ring not rejected");

  a_tick_period: assert property (
    tick |-> tick_since == (PRE_W+1)'(TICK_PERIOD))
    else $error("step tick period wrong");

  a_enable_gate: assert property (
    !enable |=> !ring_active_out && !ring_detect_out && cad_cnt == '0)
    else $error("qualification ran while disabled");

  a_confirm_hold: assert property (
    state == RCQ_QUAL && !phase_done |=> state != RCQ_DELAY)
    else $error("ring confirmed before confirmation time");

  a_delay_zero: assert property (
    state == RCQ_DELAY && ctrl[CTRL_DLY_LSB +: 3] == 3'h0 && enable && !invalid &&
      !ring_over |=> ring_detect_out ##1 (ring_detect_out || $past(ring_over || !enable)))
    else $error("zero delay did not indicate at once");

  a_detect_source: assert property (
    $rose(ring_detect_out) |-> $past(state) == RCQ_DELAY && status[ST_IND])
    else $error("ring indicated without delay phase");

  a_timeout_end: assert property (
    ring_over |=> !ring_active_out && status[ST_END] && state == RCQ_IDLE)
    else $error("ring did not end on timeout");

  c_ring_shown: cover property (ev_indicate);
  c_too_slow:   cover property (too_slow);
  c_too_fast:   cover property (too_fast);
  c_ring_ended: cover property (ring_over && state == RCQ_RING);

endmodule
`default_nettype wire

// >>> hw/rcq_pkg.sv
// Constants, types and decode functions for the ring cadence qualifier
`default_nettype none
package rcq_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ        = 40_000_000;
  localparam int TICK_MS       = 2;
  localparam int TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
  localparam int PRE_W         = 17;
  localparam int TMR_W         = 10;
  localparam int CAD_W         = 6;
  localparam int RTO_80_MS     = 80;
  localparam int RTO_128_MS    = 128;
  localparam int RTO_256_MS    = 256;
  localparam int DELAY_STEP_MS = 256;
  localparam int CONFIRM_MS [8] = '{100, 150, 200, 256, 384, 512, 640, 1024};

  // ----------------------------------------
  // Register map and fields
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_MINF  = 8'h04;
  localparam logic [7:0] OFS_TMOX  = 8'h08;
  localparam logic [7:0] OFS_STAT  = 8'h0C;
  localparam logic [7:0] OFS_MASK  = 8'h10;
  localparam logic [7:0] OFS_STATE = 8'h14;

  localparam logic [7:0]       CTRL_RST = 8'h88;
  localparam logic [CAD_W-1:0] MINF_RST = 6'h19;
  localparam logic [7:0]       TMOX_RST = 8'h16;

  localparam int CTRL_EN_BIT  = 7;
  localparam int CTRL_DLY_LSB = 4;
  localparam int CTRL_CC_LSB  = 1;
  localparam int TMOX_RTO_LSB = 4;
  localparam int TMOX_RMX_LSB = 0;
  localparam int SR_DET_BIT   = 8;
  localparam int SR_ACT_BIT   = 9;

  localparam int ST_W   = 3;
  localparam int ST_IND = 0;
  localparam int ST_INV = 1;
  localparam int ST_END = 2;

  typedef enum logic [1:0] {RCQ_IDLE, RCQ_QUAL, RCQ_DELAY, RCQ_RING} rcq_state_t;

  // ----------------------------------------
  // Decoders
  // ----------------------------------------
  function automatic logic [TMR_W-1:0] ms_to_ticks(input int ms);
    return TMR_W'(ms / TICK_MS);
  endfunction

  function automatic logic [TMR_W-1:0] rto_ticks(input logic [3:0] code);
    int ms;
    ms = (code == 4'h0) ? RTO_80_MS : (code == 4'h1) ? RTO_128_MS : RTO_256_MS;
    return ms_to_ticks(ms);
  endfunction

  function automatic logic [TMR_W-1:0] confirm_ticks(input logic [2:0] code);
    return ms_to_ticks(CONFIRM_MS[code]);
  endfunction

  function automatic logic [TMR_W-1:0] delay_ticks(input logic [2:0] code);
    return ms_to_ticks(DELAY_STEP_MS * int'(code));
  endfunction

endpackage
`default_nettype wire

// >>> hw/rcq_tick_gen.sv
// Prescaler that turns the system clock into the 2 ms step tick
`default_nettype none
module rcq_tick_gen
  import rcq_pkg::*;
#(
  parameter int CYCLES = TICK_CYCLES
)
(
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic clear_in,
  output logic      tick_out
);

  localparam logic [PRE_W-1:0] LAST = PRE_W'(CYCLES - 1);

  logic [PRE_W-1:0] count;

  // Restarted on each event so that a step is measured from the event
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      count <= '0;
    else if (clear_in || count == LAST)
      count <= '0;
    else
      count <= count + 1'b1;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      tick_out <= 1'b0;
    else
      tick_out <= !clear_in && (count == LAST);
  end

endmodule
`default_nettype wire

// >>> hw/rcq_tick_timer.sv
// Saturating tick counter that reports when a programmed limit is reached
`default_nettype none
module rcq_tick_timer
  import rcq_pkg::*;
(
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic             clear_in,
  input  wire logic             tick_in,
  input  wire logic [TMR_W-1:0] limit_in,
  output logic                  done_out
);

  logic [TMR_W-1:0] count;

  // Saturates so a long wait never wraps back below the limit
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      count <= '0;
    else if (clear_in)
      count <= '0;
    else if (tick_in && count < limit_in)
      count <= count + 1'b1;
  end

  assign done_out = (count >= limit_in);

endmodule
`default_nettype wire

// >>> tb/rcq_line_model.sv
// Line-side crossing detector model that emits tip/ring event pulses
`default_nettype none
module rcq_line_model
  import rcq_pkg::*;
(
  input  wire logic clk_in,
  output var  logic event_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Event pulses
  // ----------------------------------------
  initial event_out = 1'b0;

  // The line stays quiet between crossings; gap is edge-to-edge spacing in cycles
  task automatic pulse_train(input int count, input int gap);
    for (int i = 0; i < count; i++)
    begin
      if (i > 0)
        repeat (gap - 2) @(posedge clk_in);
      @(posedge clk_in);
      event_out <= 1'b1;
      @(posedge clk_in);
      event_out <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// >>> tb/ring_cadence_qualifier_test.sv
// Self-checking testbench for the ring cadence qualifier
`default_nettype none
module ring_cadence_qualifier_test
  import rcq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Setup
  // ----------------------------------------
  // Short step keeps every millisecond figure scaled to TP cycles per 2 ms
  localparam int TP    = 20;
  localparam int LIMIT = 40000;

  typedef struct {
    logic       we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [7:0] wd;
    logic [7:0] exp;
  } rcq_row_t;
  typedef struct {
    int   gap;
    logic rej;
  } rcq_cad_t;

  logic        clk_in = 1'b0;
  logic        rst_in;
  logic        wb_cyc;
  logic        wb_stb;
  logic        wb_we;
  logic [7:0]  wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_dat;
  logic [31:0] rd_dat;
  logic        ack;
  logic        ring_det;
  logic        ring_act;
  logic        irq;
  logic        line_event;
  int          fail_count = 0;
  int          n_tests = 0;
  int          cycles = 0;
  int          rto_ms [3] = '{80, 128, 256};

  rcq_row_t regs [17] = '{
    '{1'b0, OFS_CTRL, 4'h1, 8'h00, 8'h88}, '{1'b0, OFS_MINF, 4'h1, 8'h00, 8'h19},
    '{1'b0, OFS_TMOX, 4'h1, 8'h00, 8'h16}, '{1'b0, OFS_STAT, 4'h1, 8'h00, 8'h00},
    '{1'b0, OFS_MASK, 4'h1, 8'h00, 8'h00}, '{1'b0, 8'h18, 4'h1, 8'h00, 8'h00},
    '{1'b1, OFS_MINF, 4'h1, 8'hFF, 8'h00}, '{1'b0, OFS_MINF, 4'h1, 8'h00, 8'h3F},
    '{1'b1, OFS_MINF, 4'h0, 8'h00, 8'h00}, '{1'b0, OFS_MINF, 4'h1, 8'h00, 8'h3F},
    '{1'b1, OFS_TMOX, 4'h1, 8'hA5, 8'h00}, '{1'b0, OFS_TMOX, 4'h1, 8'h00, 8'hA5},
    '{1'b1, 8'h18, 4'h1, 8'hFF, 8'h00}, '{1'b0, 8'h18, 4'h1, 8'h00, 8'h00},
    '{1'b1, OFS_CTRL, 4'h1, 8'h81, 8'h00}, '{1'b0, OFS_CTRL, 4'h1, 8'h00, 8'h80},
    '{1'b1, OFS_TMOX, 4'h1, 8'h16, 8'h00}};
  // Spacings near the accept limits sit mid-step so counter values are unambiguous
  rcq_cad_t cads [7] = '{'{100, 1'b1}, '{370, 1'b1}, '{390, 1'b0}, '{410, 1'b0},
                        '{490, 1'b0}, '{510, 1'b1}, '{600, 1'b1}};

  always #12.5 clk_in = ~clk_in;

  rcq_top #(.TICK_PERIOD(TP)) i_dut (
    .clk_in(clk_in), .rst_in(rst_in), .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb),
    .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(wb_sel), .wb_dat_in(wb_dat),
    .wb_dat_out(rd_dat), .wb_ack_out(ack), .tip_ring_event_in(line_event),
    .ring_detect_out(ring_det), .ring_active_out(ring_act), .irq_out(irq));

  rcq_line_model i_line (.clk_in(clk_in), .event_out(line_event));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] seen);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  task automatic check_range(input string name, input int lo, input int hi, input int seen);
    n_tests++;
    if (seen < lo || seen > hi)
    begin
      fail_count++;
      $display("unexpected %s: expected %0d to %0d, seen %0d", name, lo, hi, seen);
    end
  endtask

  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                         input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_in);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= adr;
    wb_sel <= sel;
    wb_dat <= wd;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    if (n >= 50)
      fail_count++;
    rd = rd_dat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [7:0] wd);
    logic [31:0] d;
    wb_xfer(1'b1, adr, 4'h1, {24'h00_0000, wd}, d);
  endtask

  task automatic rd(input logic [7:0] adr, output logic [31:0] d);
    wb_xfer(1'b0, adr, 4'h1, 32'h0000_0000, d);
  endtask

  // Toggling enable forces the idle state, then stale status is cleared
  task automatic restart();
    wr(OFS_CTRL, 8'h00);
    wr(OFS_CTRL, 8'h80);
    wr(OFS_STAT, 8'h07);
  endtask

  always @(posedge clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      fail_count++;
      tally_and_finish();
    end
  end

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    logic [31:0] d;
    int          t;
    int          exp;
    rst_in = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we  = 1'b0;
    wb_adr = 8'h00;
    wb_sel = 4'h0;
    wb_dat = 32'h0000_0000;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    check_val("ring_active_out", 32'h0, {31'h0, ring_act});
    foreach (regs[i])
    begin
      wb_xfer(regs[i].we, regs[i].adr, regs[i].sel, {24'hFF_FFFF, regs[i].wd}, d);
      if (!regs[i].we)
        check_val("register read", {24'h00_0000, regs[i].exp}, d);
    end
    wr(OFS_MINF, 8'h19);
    foreach (cads[i])
    begin
      restart();
      i_line.pulse_train(2, cads[i].gap);
      rd(OFS_STAT, d);
      check_val("reject flag", {31'h0, cads[i].rej}, {31'h0, d[1]});
      rd(OFS_STATE, d);
      check_val("cadence counter", 32'h19, {26'h0, d[5:0]});
      check_val("ring_active_out", 32'h1, {31'h0, ring_act});
    end
    wr(OFS_CTRL, 8'h00);
    wr(OFS_STAT, 8'h07);
    i_line.pulse_train(3, 410);
    check_val("ring_active_out", 32'h0, {31'h0, ring_act});
    rd(OFS_STATE, d);
    check_val("state register", 32'h0, d);
    for (int k = 0; k < 3; k++)
    begin
      restart();
      wr(OFS_TMOX, {k[3:0], 4'h6});
      // Second pass uses the 150 ms confirm code; still confirmed before the check
      if (k == 1)
        wr(OFS_CTRL, 8'h82);
      wr(OFS_MASK, 8'h01);
      i_line.pulse_train(3, 410);
      check_val("ring_detect_out early", 32'h0, {31'h0, ring_det});
      repeat (408) @(posedge clk_in);
      i_line.pulse_train(3, 410);
      check_val("ring_detect_out", 32'h1, {31'h0, ring_det});
      check_val("irq_out", 32'h1, {31'h0, irq});
      t = 0;
      while (ring_det === 1'b1 && t < 8000)
      begin
        @(posedge clk_in);
        t++;
      end
      exp = rto_ms[k] / 2 * TP;
      check_range("ring end time", exp - TP - 5, exp + TP + 5, t);
      rd(OFS_STAT, d);
      check_val("status", 32'h5, d);
      wr(OFS_STAT, 8'h01);
      check_val("irq_out masked", 32'h0, {31'h0, irq});
      rd(OFS_STAT, d);
      check_val("status cleared", 32'h4, d);
    end
    // 256 ms indicate delay holds the ring back until after the ninth well-spaced event; ten are sent
    restart();
    wr(OFS_CTRL, 8'h90);
    wr(OFS_TMOX, 8'h26);
    i_line.pulse_train(6, 410);
    check_val("ring_detect_out in delay", 32'h0, {31'h0, ring_det});
    check_val("ring_active_out in delay", 32'h1, {31'h0, ring_act});
    repeat (408) @(posedge clk_in);
    i_line.pulse_train(4, 410);
    check_val("ring_detect_out delayed", 32'h1, {31'h0, ring_det});
    // Reset in mid-ring must drop the outputs and restore every register default; status is not read back
    wr(OFS_MINF, 8'h2A);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    check_val("ring_detect_out after reset", 32'h0, {31'h0, ring_det});
    check_val("ring_active_out after reset", 32'h0, {31'h0, ring_act});
    check_val("irq_out after reset", 32'h0, {31'h0, irq});
    rd(OFS_CTRL, d);
    check_val("control after reset", 32'h88, d);
    rd(OFS_MINF, d);
    check_val("assertion field after reset", 32'h19, d);
    rd(OFS_TMOX, d);
    check_val("timeout register after reset", 32'h16, d);
    rd(OFS_MASK, d);
    check_val("mask after reset", 32'h0, d);
    rd(OFS_STATE, d);
    check_val("state after reset", 32'h0, d);
    tally_and_finish();
  end
endmodule
`default_nettype wire
